// ---- hdl/cfgw0_cfg.svh ----
/*
  Constants for the charger configuration word zero: command code, reset value and
  field positions. Assumes it is included once per compilation unit by its bare name.
*/
`ifndef CFGW0_CFG_SVH
`define CFGW0_CFG_SVH

`define CFGW0_ADDR          8'h12
`define CFGW0_RESET         16'he70e
`define CFGW0_BIT_LOWPWR    15
`define CFGW0_BIT_WDT_HI    14
`define CFGW0_BIT_WDT_LO    13
`define CFGW0_BIT_IIN_AUTO  12
`define CFGW0_BIT_REV_AGOOD 11
`define CFGW0_BIT_OOA       10
`define CFGW0_BIT_FREQ      9
`define CFGW0_BIT_STRONG    8
`define CFGW0_BIT_CMP_LATCH 7
`define CFGW0_BIT_IIN_EN    1
`define CFGW0_ZERO16        16'h0000

`endif

// ---- hdl/cfgw0_pkg.sv ----
/*
  Types shared by the configuration word zero block.
  Assumes the constants header is available on the include path.
*/
package cfgw0_pkg;
  typedef logic [15:0] cfgw0_word_t;
  typedef logic [7:0]  cfgw0_cmd_t;
endpackage

// ---- hdl/cfgw0_reg.sv ----
/*
  Charger configuration word zero: a 16-bit read/write register at command 12h behind
  the device's serial command port, plus the power-mode steering decoded from it.
  Assumes the serial protocol engine, on the same clock, presents one-cycle write and
  read strobes with the command code, that the auto-off event comes from logic on
  this clock, and that the adapter and comparator inputs are asynchronous levels.
*/
// Contract
// - Word at command 12h, read/write, resets to e70e.
// - Bit 15 set with battery only shuts regulator, alert, buffers, comparator, ADC.
// - Bit 15 clear with battery only: performance mode, blocks follow own settings.
// - In low power, comparator and low-power alert run when its enable is set.
// - Bit 10 clamps minimum burst frequency near 25 kHz, forward and reverse.
// - Bit 9 picks switching rate: 0 is 1200 kHz, 1 is 800 kHz.
// - Bit 8 at 0 gives strong high-side turn-on drive; 1 disables it.
// - Device clears input limit loop enable when auto-off turns loop off.
// - Latch enable set latches low comparator; toggling the bit clears it.
`timescale 1ns/1ns
`include "cfgw0_cfg.svh"

module cfgw0_reg
(
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  sys_rst,
  // Command port from the serial engine
  input  wire logic                  wr_strobe,
  input  wire logic                  rd_strobe,
  input  wire cfgw0_pkg::cfgw0_cmd_t cmd,
  input  wire cfgw0_pkg::cfgw0_word_t wr_data,
  output logic                       rd_valid,
  output cfgw0_pkg::cfgw0_word_t     rd_data,
  // Power path and analogue status
  input  wire logic                  adapter_present,
  input  wire logic                  hot_alert_low_power_enable,
  input  wire logic                  hot_alert_cfg_enable,
  input  wire logic                  monitor_cfg_enable,
  input  wire logic                  comparator_cfg_enable,
  input  wire logic                  adc_cfg_enable,
  input  wire logic                  comparator_raw,
  input  wire logic                  input_limit_auto_off_event,
  // Controls to the power stage
  output logic                       internal_regulator_output,
  output logic                       hot_alert_on,
  output logic                       monitor_buffers_on,
  output logic                       comparator_on,
  output logic                       adc_on,
  output logic                       audio_band_avoid_enable,
  output logic                       switching_rate_select,
  output logic                       strong_gate_drive_disable,
  output logic                       input_limit_loop_enable,
  output logic                       comparator_output_pin,
  output logic [1:0]                 watchdog_period_adjust,
  output logic                       input_limit_auto_off,
  output logic                       reverse_mode_on_adapter_good
);
  import cfgw0_pkg::*;

  cfgw0_word_t word;
  cfgw0_word_t next_word;
  logic        cmp_latched;
  logic        next_cmp_latched;
  logic        rd_valid_q;
  logic        next_rd_valid;
  cfgw0_word_t rd_data_q;
  cfgw0_word_t next_rd_data;
  logic [4:0]  pwr_q;
  logic [4:0]  next_pwr;
  logic        low_power;
  logic        hit_wr;
  logic        next_cmp_pin;
  logic        adapter_sync_a;
  logic        adapter_sync_b;
  logic        cmp_sync_a;
  logic        cmp_sync_b;

  function automatic logic addr_hit(input cfgw0_cmd_t c);
    addr_hit = (c == `CFGW0_ADDR);
  endfunction

  assign hit_wr    = wr_strobe && addr_hit(cmd);

  // Adapter and comparator levels come from the analogue side, so two flops each keep
  // a metastable sample away from the mode decode and the latch. The comparator
  // stages reset high, its idle level, so leaving reset never looks like a trigger.
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      adapter_sync_a <= 1'b0;
      adapter_sync_b <= 1'b0;
      cmp_sync_a     <= 1'b1;
      cmp_sync_b     <= 1'b1;
    end
    else
    begin
      adapter_sync_a <= adapter_present;
      adapter_sync_b <= adapter_sync_a;
      cmp_sync_a     <= comparator_raw;
      cmp_sync_b     <= cmp_sync_a;
    end
  end

  // Low power only takes effect on battery; a host that sets it with an adapter
  // present is tolerated, the bit simply has no effect until the adapter leaves.
  assign low_power = word[`CFGW0_BIT_LOWPWR] && !adapter_sync_b;

  always_comb
  begin
    next_word = word;
    if (hit_wr)
    begin
      next_word = wr_data;
    end
    // The auto-off event wins over a same-cycle host write of the enable bit.
    if (input_limit_auto_off_event)
    begin
      next_word[`CFGW0_BIT_IIN_EN] = 1'b0;
    end
  end

  always_comb
  begin
    next_cmp_latched = cmp_latched;
    if (!word[`CFGW0_BIT_CMP_LATCH])
    begin
      next_cmp_latched = 1'b0;
    end
    else if (!cmp_sync_b)
    begin
      next_cmp_latched = 1'b1;
    end
    // Writing the latch enable to 0 clears the held output on the next cycle.
    if (hit_wr && !wr_data[`CFGW0_BIT_CMP_LATCH])
    begin
      next_cmp_latched = 1'b0;
    end
    next_cmp_pin = next_cmp_latched ? 1'b0 : cmp_sync_b;
  end

  always_comb
  begin
    next_rd_valid = rd_strobe;
    next_rd_data  = `CFGW0_ZERO16;
    if (rd_strobe && addr_hit(cmd))
    begin
      next_rd_data = word;
    end
  end

  always_comb
  begin
    if (low_power)
    begin
      next_pwr[0] = 1'b0;
      next_pwr[1] = hot_alert_low_power_enable;
      next_pwr[2] = 1'b0;
      next_pwr[3] = hot_alert_low_power_enable;
      next_pwr[4] = 1'b0;
    end
    else
    begin
      next_pwr[0] = 1'b1;
      next_pwr[1] = hot_alert_cfg_enable;
      next_pwr[2] = monitor_cfg_enable;
      next_pwr[3] = comparator_cfg_enable;
      next_pwr[4] = adc_cfg_enable;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      word        <= `CFGW0_RESET;
      cmp_latched <= 1'b0;
      rd_valid_q  <= 1'b0;
      rd_data_q   <= `CFGW0_ZERO16;
      pwr_q       <= 5'h00;
    end
    else
    begin
      word        <= next_word;
      cmp_latched <= next_cmp_latched;
      rd_valid_q  <= next_rd_valid;
      rd_data_q   <= next_rd_data;
      pwr_q       <= next_pwr;
    end
  end

  // The pin is registered so that it leaves the block straight from a flip-flop.
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      comparator_output_pin <= 1'b1;
    end
    else
    begin
      comparator_output_pin <= next_cmp_pin;
    end
  end

  assign rd_valid                     = rd_valid_q;
  assign rd_data                      = rd_data_q;
  assign internal_regulator_output    = pwr_q[0];
  assign hot_alert_on                 = pwr_q[1];
  assign monitor_buffers_on           = pwr_q[2];
  assign comparator_on                = pwr_q[3];
  assign adc_on                       = pwr_q[4];
  assign audio_band_avoid_enable      = word[`CFGW0_BIT_OOA];
  assign switching_rate_select        = word[`CFGW0_BIT_FREQ];
  assign strong_gate_drive_disable    = word[`CFGW0_BIT_STRONG];
  assign input_limit_loop_enable      = word[`CFGW0_BIT_IIN_EN];
  assign watchdog_period_adjust       = word[`CFGW0_BIT_WDT_HI:`CFGW0_BIT_WDT_LO];
  assign input_limit_auto_off         = word[`CFGW0_BIT_IIN_AUTO];
  assign reverse_mode_on_adapter_good = word[`CFGW0_BIT_REV_AGOOD];

  chk_write_then_read: assert property (@(posedge clock) disable iff (sys_rst)
    (hit_wr && !input_limit_auto_off_event) |=> (word == $past(wr_data)))
    else $error("write to word zero not stored");
  chk_lowpwr_regulator: assert property (@(posedge clock) disable iff (sys_rst)
    low_power |=> !internal_regulator_output && !adc_on)
    else $error("regulator or adc on in low power");
  chk_perf_regulator: assert property (@(posedge clock) disable iff (sys_rst)
    !low_power |=> internal_regulator_output && (adc_on == $past(adc_cfg_enable)))
    else $error("performance mode not followed");
  chk_lowpwr_comparator: assert property (@(posedge clock) disable iff (sys_rst)
    low_power |=> comparator_on == $past(hot_alert_low_power_enable))
    else $error("low power comparator wrong");
  chk_ooa_field: assert property (@(posedge clock) disable iff (sys_rst)
    hit_wr |=> audio_band_avoid_enable == $past(wr_data[`CFGW0_BIT_OOA]))
    else $error("burst clamp not updated");
  chk_rate_field: assert property (@(posedge clock) disable iff (sys_rst)
    hit_wr |=> switching_rate_select == $past(wr_data[`CFGW0_BIT_FREQ]))
    else $error("switching rate not updated");
  chk_drive_field: assert property (@(posedge clock) disable iff (sys_rst)
    hit_wr |=> strong_gate_drive_disable == $past(wr_data[`CFGW0_BIT_STRONG]))
    else $error("gate drive select not updated");
  chk_auto_off_clear: assert property (@(posedge clock) disable iff (sys_rst)
    input_limit_auto_off_event |=> !input_limit_loop_enable)
    else $error("loop enable not cleared");
  chk_cmp_latch_hold: assert property (@(posedge clock) disable iff (sys_rst)
    (cmp_latched && word[`CFGW0_BIT_CMP_LATCH] && !(hit_wr && !wr_data[`CFGW0_BIT_CMP_LATCH]))
      |=> !comparator_output_pin)
    else $error("latched comparator released");
endmodule

// ---- tb/cfgw0_host.sv ----
/*
  Host model for the command port of configuration word zero.
  Assumes it shares the register block's clock.
*/
`timescale 1ns/1ns
module cfgw0_host
(
  // Clock
  input  wire logic                   clock,
  // Command port
  input  wire logic                   rd_valid,
  input  wire cfgw0_pkg::cfgw0_word_t rd_data,
  output logic                        wr_strobe = 1'b0,
  output logic                        rd_strobe = 1'b0,
  output cfgw0_pkg::cfgw0_cmd_t       cmd = 8'h00,
  output cfgw0_pkg::cfgw0_word_t      wr_data = 16'h0000
);
  import cfgw0_pkg::*;
  // Low power may be set with an adapter present; nothing stops it.
  task automatic xfer(input logic w, input cfgw0_cmd_t c, input cfgw0_word_t d,
                      output logic v, output cfgw0_word_t q);
    @(posedge clock);
    wr_strobe <= w;
    rd_strobe <= !w;
    cmd       <= c;
    wr_data   <= d;
    @(posedge clock);
    wr_strobe <= 1'b0;
    rd_strobe <= 1'b0;
    // Idle lines are inverted so a stale value is never read as valid.
    cmd       <= ~c;
    wr_data   <= ~d;
    #1;
    v = rd_valid;
    q = rd_data;
  endtask
endmodule

// ---- tb/charger_option_word_zero_tb.sv ----
/*
  Self-checking bench for configuration word zero against a behavioural model.
  Assumes the register block and the host model compile beside it.
*/
`timescale 1ns/1ns
module charger_option_word_zero_tb;
  import cfgw0_pkg::*;
  logic clock = 1'b0, sys_rst = 1'b1, wr_strobe, rd_strobe, rd_valid, v, lp;
  cfgw0_cmd_t cmd;
  cfgw0_word_t wr_data, rd_data, model, q, d;
  logic adapter_present = 1'b0, hot_alert_low_power_enable = 1'b0;
  logic hot_alert_cfg_enable = 1'b0, monitor_cfg_enable = 1'b0;
  logic comparator_cfg_enable = 1'b0, adc_cfg_enable = 1'b0;
  logic comparator_raw = 1'b1, input_limit_auto_off_event = 1'b0;
  logic internal_regulator_output, hot_alert_on, monitor_buffers_on, comparator_on, adc_on;
  logic audio_band_avoid_enable, switching_rate_select, strong_gate_drive_disable;
  logic input_limit_loop_enable, comparator_output_pin, input_limit_auto_off;
  logic reverse_mode_on_adapter_good;
  logic [1:0] watchdog_period_adjust;
  int n_mismatch = 0, n_checks = 0, cyc = 0;
  cfgw0_reg dut (
    .clock                        (clock),
    .sys_rst                      (sys_rst),
    .wr_strobe                    (wr_strobe),
    .rd_strobe                    (rd_strobe),
    .cmd                          (cmd),
    .wr_data                      (wr_data),
    .rd_valid                     (rd_valid),
    .rd_data                      (rd_data),
    .adapter_present              (adapter_present),
    .hot_alert_low_power_enable   (hot_alert_low_power_enable),
    .hot_alert_cfg_enable         (hot_alert_cfg_enable),
    .monitor_cfg_enable           (monitor_cfg_enable),
    .comparator_cfg_enable        (comparator_cfg_enable),
    .adc_cfg_enable               (adc_cfg_enable),
    .comparator_raw               (comparator_raw),
    .input_limit_auto_off_event   (input_limit_auto_off_event),
    .internal_regulator_output    (internal_regulator_output),
    .hot_alert_on                 (hot_alert_on),
    .monitor_buffers_on           (monitor_buffers_on),
    .comparator_on                (comparator_on),
    .adc_on                       (adc_on),
    .audio_band_avoid_enable      (audio_band_avoid_enable),
    .switching_rate_select        (switching_rate_select),
    .strong_gate_drive_disable    (strong_gate_drive_disable),
    .input_limit_loop_enable      (input_limit_loop_enable),
    .comparator_output_pin        (comparator_output_pin),
    .watchdog_period_adjust       (watchdog_period_adjust),
    .input_limit_auto_off         (input_limit_auto_off),
    .reverse_mode_on_adapter_good (reverse_mode_on_adapter_good)
  );
  cfgw0_host u_host (
    .clock     (clock),
    .rd_valid  (rd_valid),
    .rd_data   (rd_data),
    .wr_strobe (wr_strobe),
    .rd_strobe (rd_strobe),
    .cmd       (cmd),
    .wr_data   (wr_data)
  );
  always #5 clock = ~clock;
  task automatic compare(input string nm, input cfgw0_word_t e, input cfgw0_word_t g);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic check_all();
    u_host.xfer(1'b0, 8'h12, 16'h0000, v, q);
    compare("rd_valid", 16'h0001, {15'h0, v});
    compare("word", model, q);
    compare("fields", {model[14:8], model[1]}, {watchdog_period_adjust, input_limit_auto_off,
      reverse_mode_on_adapter_good, audio_band_avoid_enable, switching_rate_select,
      strong_gate_drive_disable, input_limit_loop_enable});
    lp = model[15] & !adapter_present;
    compare("power", {!lp, lp ? hot_alert_low_power_enable : hot_alert_cfg_enable,
      !lp & monitor_cfg_enable, lp ? hot_alert_low_power_enable : comparator_cfg_enable,
      !lp & adc_cfg_enable}, {internal_regulator_output, hot_alert_on, monitor_buffers_on,
      comparator_on, adc_on});
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial
  begin
    void'($urandom(32'h5d99));
    model = 16'he70e;
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    check_all();
    u_host.xfer(1'b1, 8'h34, 16'h0000, v, q);
    u_host.xfer(1'b0, 8'h34, 16'hffff, v, q);
    compare("unmapped", 16'h0000, q);
    check_all();
    for (int i = 0; i < 14; i++)
    begin
      d = 16'($urandom);
      @(posedge clock);
      {adapter_present, hot_alert_low_power_enable, hot_alert_cfg_enable, monitor_cfg_enable,
        comparator_cfg_enable, adc_cfg_enable} <= 6'($urandom);
      u_host.xfer(1'b1, 8'h12, d, v, q);
      model = d;
      check_all();
    end
    u_host.xfer(1'b1, 8'h12, 16'h0082, v, q);
    @(posedge clock);
    input_limit_auto_off_event <= 1'b1;
    comparator_raw <= 1'b0;
    @(posedge clock);
    input_limit_auto_off_event <= 1'b0;
    comparator_raw <= 1'b1;
    model = 16'h0080;
    check_all();
    compare("cmp_pin", 16'h0000, {15'h0, comparator_output_pin});
    u_host.xfer(1'b1, 8'h12, 16'h0000, v, q);
    u_host.xfer(1'b1, 8'h12, 16'h0080, v, q);
    repeat (2) @(posedge clock);
    #1;
    compare("cmp_pin", 16'h0001, {15'h0, comparator_output_pin});
    give_verdict();
  end
endmodule
